// >>> src/smc_top.v
// Purpose: Control and status registers of the on-chip supply monitor.
// Assumes: The analog comparators and slow oscillator sit outside.
// Notes: One CPU bus cycle is one core clock with a read or write strobe.
`timescale 1ns/100ps
`include "smc_regs.vh"

module smc_top (
  input  wire       core_clk_in,       // Core clock, 10 MHz.
  input  wire       nrst_in,           // Asynchronous reset, active low.
  input  wire       clk_en_in,         // Freezes all state while low.
  input  wire       io_bank_select_in, // Extended I/O bank flag from CPU.
  input  wire [8:0] addr_in,           // Register address.
  input  wire       wr_en_in,          // Write strobe, one cycle.
  input  wire       rd_en_in,          // Read strobe, one cycle.
  input  wire [7:0] wr_data_in,        // Write data.
  input  wire       prec_cmp_2v7_in,   // Comparator: below 2.6 V trip.
  input  wire       prec_cmp_3v0_in,   // Comparator: below 2.9 V trip.
  input  wire [3:0] lv_cmp_in,         // Comparators: below each threshold.
  input  wire       slow_clk_in,       // 32 kHz oscillator, sampled.
  input  wire       power_down_in,     // System power down, high asleep.
  output reg  [7:0] rd_data_out,       // Read data, registered.
  output reg        rd_valid_out,      // Read answer valid, one cycle.
  output reg        precision_reset_out, // Request chip reset.
  output reg        low_supply_irq_out,  // Low-voltage trip event pulse.
  output reg        flash_enable_out,    // Flash may operate.
  output reg        detector_on_out,     // Detector bias on this period.
  output reg  [1:0] reset_trim_out,      // Trip range to the analog part.
  output reg  [2:0] lv_trim_out          // Threshold code to analog part.
);

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisation.
  ////////////////////////////////////////////////////////////////////////

  wire [7:0] raw_async;   // All asynchronous inputs gathered.
  wire [7:0] sync_bus;    // Their synchronised copies.
  wire       prec_2v7_s;  // Synchronised 2.6 V comparator.
  wire       prec_3v0_s;  // Synchronised 2.9 V comparator.
  wire [3:0] lv_s;        // Synchronised low-voltage comparators.
  wire       slow_s;      // Synchronised slow clock.
  wire       pd_s;        // Synchronised power down.

  assign raw_async = {power_down_in, slow_clk_in, lv_cmp_in,
                      prec_cmp_3v0_in, prec_cmp_2v7_in};

  smc_sync2 #(
    .WIDTH (8)
  ) u_sync (
    .core_clk_in (core_clk_in),
    .nrst_in     (nrst_in),
    .clk_en_in   (clk_en_in),
    .async_in    (raw_async),
    .sync_out    (sync_bus)
  );

  assign prec_2v7_s = sync_bus[0];
  assign prec_3v0_s = sync_bus[1];
  assign lv_s       = sync_bus[5:2];
  assign slow_s     = sync_bus[6];
  assign pd_s       = sync_bus[7];

  ////////////////////////////////////////////////////////////////////////
  // Register file.
  ////////////////////////////////////////////////////////////////////////

  reg  [7:0] level_ctrl_reg;  // Reset and low-voltage level selects.
  reg  [7:0] duty_trim_reg;   // Detector duty select.
  reg  [1:0] cmp_state_reg;   // Captured comparator results.
  wire [1:0] reset_level_select;
  wire [2:0] low_voltage_level_select;
  wire [1:0] duty_select;
  wire       bank_hit;        // Access aimed at the extended bank.

  assign reset_level_select       = level_ctrl_reg[`SMC_RST_LVL_HI:`SMC_RST_LVL_LO];
  assign low_voltage_level_select = level_ctrl_reg[`SMC_LV_LVL_HI:`SMC_LV_LVL_LO];
  assign duty_select              = duty_trim_reg[`SMC_DUTY_HI:`SMC_DUTY_LO];
  assign bank_hit                 = io_bank_select_in;

  // Writes land only through the masks, so reserved bits stay zero.
  always @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      level_ctrl_reg <= `SMC_LEVEL_CTRL_RST;
      duty_trim_reg  <= `SMC_DUTY_TRIM_RST;
    end
    else if (clk_en_in && wr_en_in && bank_hit)
    begin
      if (addr_in == `SMC_OFS_LEVEL_CTRL)
      begin
        level_ctrl_reg <= wr_data_in & `SMC_LEVEL_CTRL_MASK;
      end
      else if (addr_in == `SMC_OFS_DUTY_TRIM)
      begin
        duty_trim_reg <= wr_data_in & `SMC_DUTY_TRIM_MASK;
      end
    end
  end

  // Read mux; unmapped or wrong-bank reads return zero with valid.
  always @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rd_data_out  <= 8'h00;
      rd_valid_out <= 1'b0;
    end
    else if (clk_en_in)
    begin
      rd_valid_out <= rd_en_in;
      if (rd_en_in && bank_hit && addr_in == `SMC_OFS_LEVEL_CTRL)
      begin
        rd_data_out <= level_ctrl_reg;
      end
      else if (rd_en_in && bank_hit && addr_in == `SMC_OFS_CMP_STATE)
      begin
        rd_data_out <= {6'h00, cmp_state_reg};
      end
      else if (rd_en_in && bank_hit && addr_in == `SMC_OFS_DUTY_TRIM)
      begin
        rd_data_out <= duty_trim_reg;
      end
      else
      begin
        rd_data_out <= 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Comparator selection.
  ////////////////////////////////////////////////////////////////////////

  reg prec_sel;  // Precision comparator for the chosen range.
  reg lv_sel;    // Low-voltage comparator for the chosen threshold.

  // Code 11 still watches the 3 V range so software can poll it.
  always @*
  begin
    prec_sel = 1'b0;
    case (reset_level_select)
      `SMC_RST_LVL_2V7: prec_sel = prec_2v7_s;
      `SMC_RST_LVL_3V0: prec_sel = prec_3v0_s;
      `SMC_RST_LVL_OFF: prec_sel = prec_3v0_s;
      default:          prec_sel = prec_2v7_s; // Reserved code, safest range.
    endcase
  end

  // Codes without a threshold fall back to the lowest one.
  always @*
  begin
    lv_sel = lv_s[0];
    if (low_voltage_level_select[2] == 1'b0)
    begin
      lv_sel = lv_s[low_voltage_level_select[1:0]];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Wake sampling and duty sequencer on the slow clock.
  ////////////////////////////////////////////////////////////////////////

  localparam ST_AWAKE = 3'b001;  // Running, results follow comparators.
  localparam ST_SLEEP = 3'b010;  // Powered down, results held.
  localparam ST_WAKE  = 3'b100;  // Counting slow edges after release.

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg       slow_d_reg;     // Previous synchronised slow clock.
  reg [1:0] wake_cnt_reg;   // Slow rising edges since release.
  reg [9:0] duty_cnt_reg;   // Slow period counter for duty.
  reg [9:0] duty_period;    // Period length for the duty select.
  wire      slow_rise;
  wire      sample_now;

  assign slow_rise  = slow_s & ~slow_d_reg;
  assign sample_now = (state_reg == ST_AWAKE) ||
                      (state_reg == ST_WAKE && slow_rise &&
                       wake_cnt_reg == `SMC_WAKE_SAMPLE_EDGE - 2'h1);

  // Sleep follows the synchronised power down; wake ends at the capture edge.
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_AWAKE: if (pd_s) state_next = ST_SLEEP;
      ST_SLEEP: if (!pd_s) state_next = ST_WAKE;
      ST_WAKE:  if (sample_now) state_next = ST_AWAKE;
      default:  state_next = ST_AWAKE;
    endcase
  end

  // Period length in slow clock periods for each duty code.
  always @*
  begin
    case (duty_select)
      2'h0:    duty_period = `SMC_DUTY_P00;
      2'h1:    duty_period = `SMC_DUTY_P01;
      2'h2:    duty_period = `SMC_DUTY_P10;
      default: duty_period = `SMC_DUTY_P11;
    endcase
  end

  // The duty counter runs free on slow edges; on for one period of N.
  always @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      state_reg       <= ST_AWAKE;
      slow_d_reg      <= 1'b0;
      wake_cnt_reg    <= 2'h0;
      duty_cnt_reg    <= 10'h000;
      detector_on_out <= 1'b0;
    end
    else if (clk_en_in)
    begin
      state_reg  <= state_next;
      slow_d_reg <= slow_s;
      if (state_reg != ST_WAKE)
      begin
        wake_cnt_reg <= 2'h0;
      end
      else if (slow_rise)
      begin
        wake_cnt_reg <= wake_cnt_reg + 2'h1;
      end
      if (slow_rise)
      begin
        if (duty_cnt_reg >= duty_period - 10'h001)
        begin
          duty_cnt_reg <= 10'h000;
        end
        else
        begin
          duty_cnt_reg <= duty_cnt_reg + 10'h001;
        end
      end
      detector_on_out <= (duty_cnt_reg == 10'h000);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status capture and system outputs.
  ////////////////////////////////////////////////////////////////////////

  // Results are held through sleep and refreshed at the wake sample.
  always @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      cmp_state_reg       <= 2'h0;
      precision_reset_out <= 1'b0;
      low_supply_irq_out  <= 1'b0;
      flash_enable_out    <= 1'b0;
      reset_trim_out      <= 2'h0;
      lv_trim_out         <= 3'h0;
    end
    else if (clk_en_in)
    begin
      reset_trim_out <= (reset_level_select == `SMC_RST_LVL_OFF) ?
                        `SMC_RST_LVL_3V0 : reset_level_select;
      lv_trim_out    <= low_voltage_level_select;
      if (sample_now)
      begin
        cmp_state_reg[`SMC_PREC_RST_BIT]   <= prec_sel;
        cmp_state_reg[`SMC_LOW_SUPPLY_BIT] <= lv_sel;
      end
      precision_reset_out <= cmp_state_reg[`SMC_PREC_RST_BIT] &&
                             reset_level_select != `SMC_RST_LVL_OFF;
      low_supply_irq_out  <= sample_now && lv_sel &&
                             !cmp_state_reg[`SMC_LOW_SUPPLY_BIT];
      flash_enable_out    <= !cmp_state_reg[`SMC_LOW_SUPPLY_BIT] &&
                             (state_reg == ST_AWAKE);
    end
  end

endmodule

// >>> src/smc_regs.vh
// Purpose: Constants for the supply monitor control block.
// Assumes: Included by the top design file of the block; the synchroniser does not include it.
// Notes: Offsets are the addresses inside the extended I/O bank.
//
// Overview of operation
// - Registers are reached only with extended bank selected; other reads return zero.
// - Reset level 00/01 picks 2.6/2.9 V trip.
// - Level 11: no reset, status still shows.
// - Low-voltage field picks one of four thresholds.
// - Flash enabled only above low-voltage threshold.
// - Status bit 1 shows low-voltage comparator state.
// - Status bit 0 shows precision reset comparator.
// - Duty field sets detector on-time ratio.
// - Results sampled on second slow rising edge after wake.
`ifndef SMC_REGS_VH
`define SMC_REGS_VH

// Register offsets within the extended bank.
`define SMC_OFS_LEVEL_CTRL  9'h1E3
`define SMC_OFS_CMP_STATE   9'h1E4
`define SMC_OFS_DUTY_TRIM   9'h1EB

// Field positions.
`define SMC_RST_LVL_HI      5
`define SMC_RST_LVL_LO      4
`define SMC_LV_LVL_HI       2
`define SMC_LV_LVL_LO       0
`define SMC_DUTY_HI         7
`define SMC_DUTY_LO         6
`define SMC_LOW_SUPPLY_BIT  1
`define SMC_PREC_RST_BIT    0

// Write masks for the writable registers.
`define SMC_LEVEL_CTRL_MASK 8'h37
`define SMC_DUTY_TRIM_MASK  8'hC0

// Reset values.
`define SMC_LEVEL_CTRL_RST  8'h00
`define SMC_DUTY_TRIM_RST   8'h00

// Reset level codes.
`define SMC_RST_LVL_2V7     2'h0
`define SMC_RST_LVL_3V0     2'h1
`define SMC_RST_LVL_RSVD    2'h2
`define SMC_RST_LVL_OFF     2'h3

// Duty periods in slow clock periods: on-time one period of this many.
`define SMC_DUTY_P00        10'h080
`define SMC_DUTY_P01        10'h200
`define SMC_DUTY_P10        10'h020
`define SMC_DUTY_P11        10'h008

// Slow edges after power-down release at which results are captured.
`define SMC_WAKE_SAMPLE_EDGE 2'h2

`endif

// >>> src/smc_sync2.v
// Purpose: Two flip-flop synchroniser for asynchronous level inputs.
// Assumes: Inputs are levels that stay put for several clock cycles.
// Notes: The first stage is read by the second stage only.
`timescale 1ns/100ps

module smc_sync2 #(
  parameter WIDTH = 1
) (
  input  wire             core_clk_in,
  input  wire             nrst_in,
  input  wire             clk_en_in,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_reg;  // First stage, may go metastable.
  reg [WIDTH-1:0] sync_reg;  // Second stage, safe to use.

  // Both stages freeze with the clock enable so timing stays uniform.
  always @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      meta_reg <= {WIDTH{1'b0}};
      sync_reg <= {WIDTH{1'b0}};
    end
    else if (clk_en_in)
    begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;

endmodule

// >>> verification/smc_top_props.sv
// Purpose: Port-level checker for the supply monitor control block.
// Assumes: One clock domain; bound to every smc_top instance.
// Notes: Register state is judged through the trim outputs and reads.
`timescale 1ns/100ps

module smc_props (
  input wire       core_clk_in,
  input wire       nrst_in,
  input wire       clk_en_in,
  input wire       io_bank_select_in,
  input wire [8:0] addr_in,
  input wire       wr_en_in,
  input wire       rd_en_in,
  input wire [7:0] wr_data_in,
  input wire       prec_cmp_2v7_in,
  input wire       prec_cmp_3v0_in,
  input wire       power_down_in,
  input wire [7:0] rd_data_out,
  input wire       rd_valid_out,
  input wire       precision_reset_out,
  input wire       low_supply_irq_out,
  input wire       detector_on_out,
  input wire [1:0] reset_trim_out,
  input wire [2:0] lv_trim_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);

  // Status is held through sleep and the wake delay, so the quiet-input check
  // applies only once power down has been low for a long time.
  logic [9:0] awake_cnt_reg;  // Cycles since power down was last high, saturating.

  always @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      awake_cnt_reg <= 10'h3FF;
    end
    else if (power_down_in)
    begin
      awake_cnt_reg <= 10'h000;
    end
    else if (awake_cnt_reg != 10'h3FF)
    begin
      awake_cnt_reg <= awake_cnt_reg + 10'h001;
    end
  end

  // Every read made with the clock enable high gets exactly one answer, one cycle later.
  rd_valid_a: assert property (clk_en_in |=> rd_valid_out == $past(rd_en_in))
    else $error("read answer mistimed");
  rd_zero_a: assert property (clk_en_in && !(rd_en_in && io_bank_select_in) |=>
    rd_data_out == 8'h00)
    else $error("read data not zero");
  rsv_bits_a: assert property (rd_en_in && io_bank_select_in && addr_in == 9'h1E4 |=>
    rd_data_out[7:2] == 6'h00)
    else $error("status reserved bits set");
  // Code 11 must reach the analog part as the 3 V range.
  trim_map_a: assert property (reset_trim_out != 2'h3)
    else $error("reset trim shows 11");
  // Quiet comparators can never produce a reset request.
  prec_idle_a: assert property ((clk_en_in && awake_cnt_reg == 10'h3FF &&
    !prec_cmp_2v7_in && !prec_cmp_3v0_in) [*6] |-> !precision_reset_out)
    else $error("reset without trip");
  // The trim outputs trail the register by one cycle, so an accepted write
  // just before a refused one may still move them.
  wr_refused_a: assert property (clk_en_in && wr_en_in && !io_bank_select_in &&
    !$past(wr_en_in && io_bank_select_in) |=> $stable(lv_trim_out) && $stable(reset_trim_out))
    else $error("write outside bank took");
  wr_take_a: assert property (clk_en_in && wr_en_in && io_bank_select_in &&
    addr_in == 9'h1E3 |=> ##1 lv_trim_out == $past(wr_data_in[2:0], 2))
    else $error("level write lost");
  irq_pulse_a: assert property (low_supply_irq_out |=> !low_supply_irq_out)
    else $error("trip pulse too long");

  cover property (rd_valid_out);
  cover property ($rose(precision_reset_out));
  cover property (low_supply_irq_out);
  cover property ($rose(detector_on_out));
endmodule

bind smc_top smc_props smc_props_i (.core_clk_in, .nrst_in, .clk_en_in, .io_bank_select_in,
  .addr_in, .wr_en_in, .rd_en_in, .wr_data_in, .prec_cmp_2v7_in, .prec_cmp_3v0_in,
  .power_down_in, .rd_data_out, .rd_valid_out, .precision_reset_out, .low_supply_irq_out,
  .detector_on_out, .reset_trim_out, .lv_trim_out);

// >>> verification/smc_top_test.sv
// Purpose: Self-checking bench for the supply monitor control block.
// Assumes: Slow clock runs at one eighth of the core rate to keep runs short.
// Notes: Inputs change 1 ns after each rising edge.
`timescale 1ns/100ps

module smc_top_test;
  logic       clk = 0, nrst = 0, bank = 0, wr = 0, rd = 0, slow = 0, pd = 0;
  logic       c27 = 0, c30 = 0, en = 1;
  logic [8:0] addr = 9'h000;
  logic [7:0] wd = 8'h00;
  logic [3:0] lvc = 4'h0;
  wire  [7:0] rdo;
  wire        rv, prst, irq, fen, don;
  wire  [1:0] rtrim;
  wire  [2:0] lvtrim;
  int         errors = 0, checks = 0, cyc = 0;

  // Clock enable is driven so that one scenario can freeze the block.
  smc_top smc_top_i (.core_clk_in(clk), .nrst_in(nrst), .clk_en_in(en),
    .io_bank_select_in(bank), .addr_in(addr), .wr_en_in(wr), .rd_en_in(rd),
    .wr_data_in(wd), .prec_cmp_2v7_in(c27), .prec_cmp_3v0_in(c30), .lv_cmp_in(lvc),
    .slow_clk_in(slow), .power_down_in(pd), .rd_data_out(rdo), .rd_valid_out(rv),
    .precision_reset_out(prst), .low_supply_irq_out(irq), .flash_enable_out(fen),
    .detector_on_out(don), .reset_trim_out(rtrim), .lv_trim_out(lvtrim));

  initial forever #50 clk = ~clk;
  // A fast slow clock: eight core cycles a period.
  initial forever
  begin
    repeat (4) @(posedge clk);
    #1 slow = ~slow;
  end

  task automatic close_out;
    if (errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e)
    begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic wreg(input logic [8:0] a, input logic [7:0] d, input logic b);
    @(posedge clk) #1;
    addr = a; wd = d; bank = b; wr = 1;
    @(posedge clk) #1;
    wr = 0;
  endtask

  // Read strobe for one cycle; answer is looked at in the following cycle.
  task automatic rreg(input logic [8:0] a, input logic b, input logic [7:0] e);
    @(posedge clk) #1;
    addr = a; bank = b; rd = 1;
    @(posedge clk) #1;
    rd = 0;
    check(16'(rv), 1);
    check({8'h00, rdo}, {8'h00, e});
  endtask

  // Comparators need three edges to reach status; six gives margin.
  task automatic settle;
    repeat (6) @(posedge clk);
    #1;
  endtask

  task automatic t_regs;
    rreg(9'h1E3, 1, 8'h00);
    rreg(9'h1EB, 1, 8'h00);
    wreg(9'h1E3, 8'hFF, 0);
    rreg(9'h1E3, 1, 8'h00);
    wreg(9'h1E3, 8'hFF, 1);
    rreg(9'h1E3, 0, 8'h00);
    rreg(9'h1E3, 1, 8'h37);
    check(16'(lvtrim), 7);
    // A write while the clock enable is low must leave no trace.
    en = 0;
    wreg(9'h1E3, 8'h00, 1);
    en = 1;
    rreg(9'h1E3, 1, 8'h37);
    check(16'(lvtrim), 7);
    wreg(9'h1EB, 8'hFF, 1);
    rreg(9'h1EB, 1, 8'hC0);
    wreg(9'h1E4, 8'hFF, 1);
    rreg(9'h1E4, 1, 8'h00);
    rreg(9'h1E5, 1, 8'h00);
  endtask

  // Each level code against each single tripped comparator.
  task automatic t_rlev;
    logic e;
    for (int i = 0; i < 4; i++)
      for (int k = 0; k < 2; k++)
      begin
        wreg(9'h1E3, {2'h0, i[1:0], 4'h0}, 1);
        c27 = !k[0];
        c30 = k[0];
        settle;
        e = i[0] ? c30 : c27;
        rreg(9'h1E4, 1, {7'h00, e});
        check(16'(prst), 16'(e && i != 3));
        check(16'(rtrim), i == 3 ? 1 : i);
      end
    c27 = 0;
    c30 = 0;
  endtask

  // Only the selected threshold may trip; all others are set high.
  task automatic t_lv;
    int p;
    for (int n = 0; n < 4; n++)
    begin
      wreg(9'h1E3, n[7:0], 1);
      lvc = ~(4'h1 << n);
      settle;
      rreg(9'h1E4, 1, 8'h00);
      check(16'(fen), 1);
      lvc = 4'h1 << n;
      p = 0;
      repeat (8) @(posedge clk) #1 p += irq;
      check(16'(p), 1);
      rreg(9'h1E4, 1, 8'h02);
      check(16'(fen), 0);
    end
    lvc = 0;
  endtask

  task automatic rise(inout int len);
    while (don !== 1'b0) begin @(posedge clk) #1; len++; end
    while (don !== 1'b1) begin @(posedge clk) #1; len++; end
  endtask

  // Rise to rise of the on window is the duty period times eight cycles.
  task automatic t_duty;
    int n [4] = '{128, 512, 32, 8};
    int len;
    for (int c = 0; c < 4; c++)
    begin
      wreg(9'h1EB, {c[1:0], 6'h00}, 1);
      rise(len);
      len = 0;
      rise(len);
      check(16'(len), 16'(n[c] * 8));
    end
  endtask

  // Status holds while asleep and is taken again after wake.
  task automatic t_wake;
    wreg(9'h1E3, 8'h00, 1);
    pd = 1;
    settle;
    lvc = 4'h1;
    settle;
    rreg(9'h1E4, 1, 8'h00);
    check(16'(fen), 0);
    // Release on a slow rise: that rise reaches the sequencer while it is still asleep, the
    // next one is the first after release and the one after it captures.
    @(posedge slow);
    pd = 0;
    repeat (12) @(posedge clk);
    rreg(9'h1E4, 1, 8'h00);
    repeat (8) @(posedge clk);
    rreg(9'h1E4, 1, 8'h02);
    lvc = 0;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      errors++;
      close_out;
    end
  end

  initial
  begin
    repeat (10) @(posedge clk);
    #1 nrst = 1;
    t_regs;
    t_rlev;
    t_lv;
    t_duty;
    t_wake;
    close_out;
  end
endmodule
